// *** hw/rrc_unit.sv ***
// Rotate-right-through-carry execution unit with its own file and W
`timescale 1ns/1ps
`include "rrc_cfg.svh"
module rrc_unit (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input wire logic [11:0] instr_in,
    input wire rrc_pkg::rrc_preset_t preset_in,
    input wire logic [4:0] peek_addr_in,
    output logic done_out,
    output logic [7:0] result_out,
    output logic [7:0] w_out,
    output rrc_pkg::rrc_flags_t flags_out,
    output logic [7:0] peek_data_out
);

    rrc_pkg::rrc_instr_t instr;
    logic exec;
    logic [7:0] src_data;
    logic [7:0] rot_res;
    logic rot_carry;
    logic [7:0] file_q [`RRC_NUM_REGS];
    logic [7:0] w_q;
    rrc_pkg::rrc_flags_t flags_q;
    logic done_q;
    logic [7:0] result_q;
    logic [7:0] peek_q;

    // Opcode match, shared by the decoder and its checks
    function automatic logic rrc_is_rotate(input logic [11:0] word);
        return word[`RRC_OPC_MSB:`RRC_OPC_LSB] == `RRC_OPC_VALUE;
    endfunction

    // Field split and opcode match
    always_comb begin
        instr = rrc_pkg::rrc_instr_t'(instr_in);
        exec = instr_valid_in && rrc_is_rotate(instr_in);
    end

    // Five-bit address reaches every one of the 32 registers
    assign src_data = file_q[instr.addr];

    // Rotator kept apart so its data path stays free of control
    rrc_rot u_rot (
        .data_in(src_data),
        .carry_in(flags_q.c),
        .result_out(rot_res),
        .carry_out(rot_carry)
    );

    // Register file; presets are refused while an instruction executes
    // so the two writers never race on the same entry
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < `RRC_NUM_REGS; i++) begin
                file_q[i] <= `RRC_FILE_RESET;
            end
        end else if (exec) begin
            if (instr.dest) begin
                file_q[instr.addr] <= rot_res;
            end
        end else if (preset_in.file_we) begin
            file_q[preset_in.file_addr] <= preset_in.file_data;
        end
    end

    // Working accumulator
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            w_q <= `RRC_W_RESET;
        end else if (exec) begin
            if (!instr.dest) begin
                w_q <= rot_res;
            end
        end else if (preset_in.w_we) begin
            w_q <= preset_in.w_data;
        end
    end

    // Status flags; the instruction touches carry alone
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_q <= '0;
        end else if (exec) begin
            flags_q.c <= rot_carry;
        end else if (preset_in.flags_we) begin
            flags_q <= preset_in.flags;
        end
    end

    // Completion strobe in the cycle after the taking edge
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_q <= 1'b0;
            result_q <= 8'h00;
        end else begin
            done_q <= exec;
            if (exec) begin
                result_q <= rot_res;
            end
        end
    end

    // Registered read port, sees the file before this edge's write
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            peek_q <= 8'h00;
        end else begin
            peek_q <= file_q[peek_addr_in];
        end
    end

    // Outputs come straight from the registers
    assign done_out = done_q;
    assign result_out = result_q;
    assign w_out = w_q;
    assign flags_out = flags_q;
    assign peek_data_out = peek_q;

    // Checks, all on the one clock and quiet while reset is low
    // Flags and file are held against their values one edge earlier
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    // Building blocks for the timing checks
    sequence s_take;
        exec;
    endsequence

    sequence s_take_alone;
        exec ##1 !exec;
    endsequence

    // Two executes on consecutive edges, carry handed along
    sequence s_chain;
        exec ##1 exec;
    endsequence

    chk_decode_fire: assert property (
        (instr_valid_in && rrc_is_rotate(instr_in)) |=> done_q)
        else $error("matching opcode did not complete");

    chk_decode_miss: assert property (
        (!instr_valid_in || !rrc_is_rotate(instr_in)) |=> !done_q)
        else $error("non-matching word was executed");

    chk_rotate_value: assert property (
        s_take |=> result_q == {$past(flags_q.c), $past(src_data[7:1])})
        else $error("rotate result wrong");

    chk_carry_out: assert property (
        s_take |=> flags_q.c == $past(src_data[0]))
        else $error("carry not taken from bit 0");

    chk_dest_w: assert property (
        (exec && !instr.dest) |=> (w_q == result_q) &&
            (file_q[$past(instr.addr)] == $past(src_data)))
        else $error("dest 0 wrote wrong target");

    chk_dest_file: assert property (
        (exec && instr.dest) |=> (w_q == $past(w_q)) &&
            (file_q[$past(instr.addr)] == result_q))
        else $error("dest 1 wrote wrong target");

    chk_addr_range: assert property (
        (exec && instr.dest && instr.addr == 5'h1f) |=>
            file_q[31] == result_q)
        else $error("top register not reached");

    chk_flags_kept: assert property (
        s_take |=> flags_q.z == $past(flags_q.z) &&
            flags_q.dc == $past(flags_q.dc))
        else $error("zero or digit carry changed");

    chk_single_cycle: assert property (
        s_take_alone |=> !done_q)
        else $error("completion strobe too long");

    // A strobe is only ever the echo of a taken word
    chk_done_cause: assert property (
        done_q |-> $past(exec))
        else $error("strobe without an execute");

    // Result holds between executes, so a late reader still sees it
    chk_result_hold: assert property (
        !exec |=> $stable(result_q))
        else $error("result changed without an execute");

    // W moves only on a dest 0 execute or a preset
    chk_w_idle: assert property (
        (!exec && !preset_in.w_we) |=> $stable(w_q))
        else $error("accumulator changed while idle");

    // Flags move only on an execute or a preset
    chk_flags_idle: assert property (
        (!exec && !preset_in.flags_we) |=> $stable(flags_q))
        else $error("flags changed while idle");

    // Second of a pair sees the carry left by the first
    chk_carry_chain: assert property (
        s_chain |=> result_q[7] == $past(src_data[0], 2))
        else $error("carry not chained between executes");

    // Bottom register is as reachable as the top one
    chk_addr_zero: assert property (
        (exec && instr.dest && instr.addr == 5'h00) |=>
            file_q[0] == result_q)
        else $error("bottom register not reached");

    // Read port shows the value from before the write-back
    chk_peek_prewrite: assert property (
        (exec && instr.dest && peek_addr_in == instr.addr) |=>
            peek_q == $past(src_data))
        else $error("read port did not show old value");

    // A zero result must not touch the zero flag
    chk_zero_result: assert property (
        (exec && rot_res == 8'h00) |=> flags_q.z == $past(flags_q.z))
        else $error("zero flag followed the result");

endmodule // rrc_unit

// *** hw/rrc_cfg.svh ***
// Constants for the rotate-right-through-carry unit
// Operation
// - Opcode bits 11:6 are 001100; bit 5 destination, bits 4:0 address.
// - Register shifts right one; old carry to bit 7, bit 0 to carry.
// - Destination 0: result to accumulator, addressed register unchanged.
// - Destination 1: result goes back to register, accumulator unchanged.
// - Address covers registers 0 to 31; destination is a single bit.
// - Only carry changes; zero and digit-carry flags stay as they were.
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH

`define RRC_OPC_VALUE 6'h0c
`define RRC_OPC_MSB 11
`define RRC_OPC_LSB 6
`define RRC_DEST_BIT 5
`define RRC_ADDR_MSB 4
`define RRC_ADDR_LSB 0
`define RRC_NUM_REGS 32
`define RRC_W_RESET 8'h00
`define RRC_FILE_RESET 8'h00
`define RRC_EXEC_CYCLES 1

`endif

// *** hw/rrc_pkg.sv ***
// Types shared by the rotate-right-through-carry unit
package rrc_pkg;

    // Instruction word split into its fields
    typedef struct packed {
        logic [5:0] opcode;
        logic dest;
        logic [4:0] addr;
    } rrc_instr_t;

    // Status flags held by the unit
    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } rrc_flags_t;

    // Preset bundle used to load state from the surrounding core
    typedef struct packed {
        logic file_we;
        logic [4:0] file_addr;
        logic [7:0] file_data;
        logic w_we;
        logic [7:0] w_data;
        logic flags_we;
        rrc_flags_t flags;
    } rrc_preset_t;

endpackage

// *** hw/rrc_rot.sv ***
// Combinational right rotate of one byte through carry
`timescale 1ns/1ps
module rrc_rot (
    input wire logic [7:0] data_in,
    input wire logic carry_in,
    output logic [7:0] result_out,
    output logic carry_out
);

    // Old carry fills the top, bit 0 falls into carry
    always_comb begin
        result_out = {carry_in, data_in[7:1]};
        carry_out = data_in[0];
    end

endmodule // rrc_rot

// *** tb/tb_top.sv ***
// Self-checking random bench for the rotate-through-carry unit
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
fail_count++; $display("BAD %0t output mismatch", $time); end end
module tb_top;
    typedef struct packed {
        logic d;
        logic [7:0] r;
        logic [7:0] w;
        rrc_pkg::rrc_flags_t f;
        logic [7:0] p;
    } rrc_exp_t;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [11:0] instr_in = 12'h000;
    rrc_pkg::rrc_preset_t preset_in = '0;
    logic [4:0] peek_addr_in = 5'h00;
    logic done_out;
    logic [7:0] result_out;
    logic [7:0] w_out;
    logic [7:0] peek_data_out;
    rrc_pkg::rrc_flags_t flags_out;
    logic [7:0] m_file [32];
    rrc_exp_t e_now = '0;
    rrc_exp_t e_nxt = '0;
    logic chk_on = 1'b0;
    int fail_count = 0;
    int check_count = 0;
    rrc_unit uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .preset_in(preset_in), .peek_addr_in(peek_addr_in),
        .done_out(done_out), .result_out(result_out), .w_out(w_out),
        .flags_out(flags_out), .peek_data_out(peek_data_out));
    // System clock, 50 ns period
    initial forever #25 clk_sys_in = ~clk_sys_in;
    // Carry enters on top, bit 0 leaves as carry
    function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
        return {v[0], c, v[7:1]};
    endfunction
    // Preset that loads one register and the flags, W left alone
    function automatic rrc_pkg::rrc_preset_t pre(input logic [4:0] a,
            input logic [7:0] d, input logic [2:0] f);
        rrc_pkg::rrc_preset_t p;
        p = '0;
        p.file_we = 1'b1;
        p.file_addr = a;
        p.file_data = d;
        p.flags_we = 1'b1;
        p.flags = rrc_pkg::rrc_flags_t'(f);
        return p;
    endfunction
    // Drive one cycle; model runs one cycle ahead of the check
    task automatic cyc(input logic v, input logic [11:0] ins,
            input rrc_pkg::rrc_preset_t p, input logic [4:0] pk);
        logic [8:0] r;
        @(posedge clk_sys_in);
        e_now = e_nxt;
        instr_valid_in <= v;
        instr_in <= ins;
        preset_in <= p;
        peek_addr_in <= pk;
        e_nxt.p = m_file[pk];
        e_nxt.d = v && ins[11:6] == 6'h0c;
        r = rot(m_file[ins[4:0]], e_nxt.f.c);
        if (e_nxt.d) begin
            e_nxt.r = r[7:0];
            e_nxt.f.c = r[8];
            if (ins[5]) m_file[ins[4:0]] = r[7:0];
            else e_nxt.w = r[7:0];
        end else begin
            // Preset only counts outside execute cycles
            if (p.file_we) m_file[p.file_addr] = p.file_data;
            if (p.w_we) e_nxt.w = p.w_data;
            if (p.flags_we) e_nxt.f = p.flags;
        end
    endtask
    // Compare at the falling edge, well after outputs settle
    always @(negedge clk_sys_in) begin
        if (chk_on) begin
            `CHK(done_out, e_now.d)
            `CHK(result_out, e_now.r)
            `CHK(w_out, e_now.w)
            `CHK(flags_out, e_now.f)
            `CHK(peek_data_out, e_now.p)
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Guard against a hang
    initial begin
        #2000000;
        fail_count++;
        results();
    end
    initial begin
        logic [11:0] ins;
        for (int i = 0; i < 32; i++) m_file[i] = 8'h00;
        void'($urandom(32'h25c3));
        repeat (4) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        chk_on = 1'b1;
        // Register 1 into W, then back to back in place, z and dc set
        cyc(1'b0, 12'h000, pre(5'h01, 8'he6, 3'h6), 5'h01);
        cyc(1'b1, 12'h301, 27'h0, 5'h01);
        cyc(1'b1, 12'h321, 27'h0, 5'h01);
        cyc(1'b1, 12'h321, 27'h7ffffff, 5'h01);
        cyc(1'b0, 12'h000, 27'h0, 5'h01);
        $display("test example done");
        // Top address, carry chained through nine rotates; z clear and
        // the first result zero, so a flag that followed it would show
        cyc(1'b0, 12'h000, pre(5'h1f, 8'h01, 3'h2), 5'h1f);
        repeat (9) cyc(1'b1, 12'h33f, 27'h0, 5'h1f);
        // Neighbouring opcodes and an invalid word must not execute
        cyc(1'b0, 12'h33f, 27'h0, 5'h1f);
        cyc(1'b1, 12'h2ff, 27'h0, 5'h1f);
        cyc(1'b1, 12'h37f, 27'h0, 5'h1f);
        // Bottom register rotated in place
        cyc(1'b1, 12'h320, 27'h0, 5'h00);
        $display("test corner done");
        // Random mix of presets, executes and other words
        repeat (400) begin
            ins = 12'($urandom);
            if ($urandom_range(1) == 1) ins[11:6] = 6'h0c;
            cyc(1'($urandom), ins, rrc_pkg::rrc_preset_t'(27'($urandom)),
                5'($urandom));
        end
        cyc(1'b0, 12'h000, 27'h0, 5'h00);
        cyc(1'b0, 12'h000, 27'h0, 5'h00);
        $display("test random done");
        results();
    end
endmodule // tb_top
